// ==== hdl/lfs_fault_map.vh ====
// constants for the led driver fault supervisor
`ifndef LFS_FAULT_MAP_VH
`define LFS_FAULT_MAP_VH

// clock and timing figures
`define LFS_CLK_KHZ         25000
`define LFS_SYNC_DELAY_US   30
`define LFS_SCP_TIMEOUT_MS  140
`define LFS_LSC_TERMINAL    16'h8002
`define LFS_SCP_WIDTH       22
`define LFS_IDLE_WIDTH      10

// register port
`define LFS_ADDR_W          4
`define LFS_DATA_W          16
`define LFS_ADDR_CTRL       4'h0
`define LFS_ADDR_OSC_DIV    4'h1
`define LFS_ADDR_STATUS     4'h2
`define LFS_ADDR_LSC_COUNT  4'h3
`define LFS_CTRL_RESET      16'h0001
`define LFS_OSC_DIV_RESET   16'h0053
`define LFS_OSC_DIV_MIN     16'h0002

// control field
`define LFS_CTRL_SYNC_ALLOW 0

// status fields
`define LFS_ST_UNDERVOLTAGE_LOCKOUT         0
`define LFS_ST_TSD          1
`define LFS_ST_OVP          2
`define LFS_ST_OCP          3
`define LFS_ST_SCP          4
`define LFS_ST_OPEN         5
`define LFS_ST_SHORT        6
`define LFS_ST_EXT          7
`define LFS_ST_SWITCH       8

// synchronised input lanes
`define LFS_NSYNC           14
`define LFS_IX_EN           0
`define LFS_IX_SYNC         1
`define LFS_IX_SUP_LO       2
`define LFS_IX_SUP_HI       3
`define LFS_IX_TEMP_HI      4
`define LFS_IX_TEMP_LO      5
`define LFS_IX_OVP_HI       6
`define LFS_IX_OVP_LO       7
`define LFS_IX_OVP_PRE      8
`define LFS_IX_CS_LOW       9
`define LFS_IX_FB_LOW       10
`define LFS_IX_SHORT        11
`define LFS_IX_DIM_ACT      12
`define LFS_IX_DIM_OUT      13

`endif

// ==== hdl/lfs_sync2.v ====
// two-stage synchroniser bank for comparator and pin inputs
`timescale 1ns/100ps
`default_nettype none
module lfs_sync2 #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             core_clk,
  input  wire             rstn,
  // lanes
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_lane
      // first stage feeds only the second
      always @(posedge core_clk) begin
        if (!rstn) begin
          stage1[i] <= 1'b0;
          stage2[i] <= 1'b0;
        end else begin
          stage1[i] <= async_in[i];
          stage2[i] <= stage1[i];
        end
      end
    end
  endgenerate

  assign sync_out = stage2;
endmodule // lfs_sync2
`default_nettype wire

// ==== hdl/lfs_fault_supervisor.v ====
// fault supervisor and oscillator source selector
`timescale 1ns/100ps
`default_nettype none
`include "lfs_fault_map.vh"
module lfs_fault_supervisor #(
  parameter SCP_TIMEOUT_CYCLES = `LFS_SCP_TIMEOUT_MS * `LFS_CLK_KHZ
) (
  // clock and reset
  input  wire                     core_clk,
  input  wire                     rstn,
  // register port
  input  wire [`LFS_ADDR_W-1:0]   reg_addr,
  input  wire [`LFS_DATA_W-1:0]   reg_wdata,
  input  wire                     reg_wr,
  input  wire                     reg_rd,
  output reg  [`LFS_DATA_W-1:0]   reg_rdata,
  // controller pins
  input  wire                     enable_in,
  input  wire                     sync_in,
  input  wire                     dim_active_in,
  input  wire                     dimming_switch_out,
  // comparator results
  input  wire                     supply_below_lo,
  input  wire                     supply_above_hi,
  input  wire                     temp_above_hi,
  input  wire                     temp_below_lo,
  input  wire                     ovp_above_hi,
  input  wire                     ovp_below_lo,
  input  wire                     ovp_above_pre,
  input  wire                     cs_below_limit,
  input  wire                     feedback_low,
  input  wire                     short_sense_diff,
  // open-drain fault pins
  output reg                      general_fault_out,
  output reg                      general_fault_oe_n,
  output reg                      led_fault_out,
  output reg                      led_fault_oe_n,
  // converter control
  output reg                      switching_on,
  output reg                      soft_start_discharge,
  output reg                      switch_tick,
  output reg                      ext_sync_active
);
  localparam [3:0] ST_OFF   = 4'b0001;
  localparam [3:0] ST_RUN   = 4'b0010;
  localparam [3:0] ST_HOLD  = 4'b0100;
  localparam [3:0] ST_LATCH = 4'b1000;

  // 30 us at the core rate, rounded down
  localparam [31:0] SYNC_WAIT_FULL =
    (`LFS_SYNC_DELAY_US * `LFS_CLK_KHZ / 1000) - 1;
  localparam [`LFS_IDLE_WIDTH-1:0] SYNC_WAIT_LAST =
    SYNC_WAIT_FULL[`LFS_IDLE_WIDTH-1:0];
  localparam [31:0] SCP_LAST = SCP_TIMEOUT_CYCLES - 1;

  wire [`LFS_NSYNC-1:0] raw;
  wire [`LFS_NSYNC-1:0] s;

  assign raw[`LFS_IX_EN]      = enable_in;
  assign raw[`LFS_IX_SYNC]    = sync_in;
  assign raw[`LFS_IX_SUP_LO]  = supply_below_lo;
  assign raw[`LFS_IX_SUP_HI]  = supply_above_hi;
  assign raw[`LFS_IX_TEMP_HI] = temp_above_hi;
  assign raw[`LFS_IX_TEMP_LO] = temp_below_lo;
  assign raw[`LFS_IX_OVP_HI]  = ovp_above_hi;
  assign raw[`LFS_IX_OVP_LO]  = ovp_below_lo;
  assign raw[`LFS_IX_OVP_PRE] = ovp_above_pre;
  assign raw[`LFS_IX_CS_LOW]  = cs_below_limit;
  assign raw[`LFS_IX_FB_LOW]  = feedback_low;
  assign raw[`LFS_IX_SHORT]   = short_sense_diff;
  assign raw[`LFS_IX_DIM_ACT] = dim_active_in;
  assign raw[`LFS_IX_DIM_OUT] = dimming_switch_out;

  lfs_sync2 #(
    .WIDTH(`LFS_NSYNC)
  ) u_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .async_in (raw),
    .sync_out (s)
  );

  // software registers
  reg [`LFS_DATA_W-1:0]  ctrl;
  reg [`LFS_DATA_W-1:0]  osc_div;

  // protection state
  reg                     undervoltage_lockout;
  reg                     thermal_shutdown;
  reg                     overvoltage_protect;
  reg                     overcurrent_protect;
  reg                     scp_latch;
  reg                     open_latch;
  reg                     short_latch;
  reg [`LFS_SCP_WIDTH-1:0] scp_cnt;
  reg [15:0]              lsc_cnt;
  reg [3:0]               state;
  reg [3:0]               next_state;

  // oscillator state
  reg                     ext_mode;
  reg                     sync_q;
  reg [`LFS_IDLE_WIDTH-1:0] idle_cnt;
  reg [15:0]              div_cnt;
  reg                     int_tick;

  wire en          = s[`LFS_IX_EN];
  wire sync_rise   = ctrl[`LFS_CTRL_SYNC_ALLOW] & s[`LFS_IX_SYNC] & ~sync_q;
  wire sw_tick     = sync_rise | (int_tick & ~ext_mode);
  wire any_latch   = scp_latch | open_latch | short_latch;
  wire latch_clear = ~en | undervoltage_lockout;
  wire run_ok      = en & ~undervoltage_lockout & ~thermal_shutdown & ~any_latch;
  wire stop_sw     = overvoltage_protect | overcurrent_protect;
  wire active      = (state == ST_RUN) | (state == ST_HOLD);
  // dimming off-time freezes the short check rather than clearing it
  wire short_eval  = ~s[`LFS_IX_DIM_ACT] | s[`LFS_IX_DIM_OUT];
  wire osc_last    = (div_cnt >= osc_div - 16'h0001);

  // hysteresis comparators held as set/clear flops; overcurrent follows its comparator directly
  always @(posedge core_clk) begin
    if (!rstn) begin
      undervoltage_lockout <= 1'b1;
      thermal_shutdown  <= 1'b0;
      overvoltage_protect  <= 1'b0;
      overcurrent_protect  <= 1'b0;
    end else begin
      if (s[`LFS_IX_SUP_LO])
        undervoltage_lockout <= 1'b1;
      else if (s[`LFS_IX_SUP_HI])
        undervoltage_lockout <= 1'b0;
      if (s[`LFS_IX_TEMP_HI])
        thermal_shutdown <= 1'b1;
      else if (s[`LFS_IX_TEMP_LO])
        thermal_shutdown <= 1'b0;
      if (s[`LFS_IX_OVP_HI])
        overvoltage_protect <= 1'b1;
      else if (s[`LFS_IX_OVP_LO])
        overvoltage_protect <= 1'b0;
      overcurrent_protect <= s[`LFS_IX_CS_LOW];
    end
  end

  // output short timer, counted in core cycles
  always @(posedge core_clk) begin
    if (!rstn) begin
      scp_cnt   <= {`LFS_SCP_WIDTH{1'b0}};
      scp_latch <= 1'b0;
    end else if (latch_clear) begin
      scp_cnt   <= {`LFS_SCP_WIDTH{1'b0}};
      scp_latch <= 1'b0;
    end else if (!active || !s[`LFS_IX_FB_LOW]) begin
      scp_cnt <= {`LFS_SCP_WIDTH{1'b0}};
    end else if ({{(32-`LFS_SCP_WIDTH){1'b0}}, scp_cnt} >= SCP_LAST) begin
      scp_latch <= 1'b1;
    end else begin
      scp_cnt <= scp_cnt + {{(`LFS_SCP_WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // led open: both comparators at once, no delay
  always @(posedge core_clk) begin
    if (!rstn)
      open_latch <= 1'b0;
    else if (latch_clear)
      open_latch <= 1'b0;
    else if (active && s[`LFS_IX_FB_LOW] && s[`LFS_IX_OVP_PRE])
      open_latch <= 1'b1;
  end

  // led short counter, one step per switching cycle
  always @(posedge core_clk) begin
    if (!rstn) begin
      lsc_cnt     <= 16'h0000;
      short_latch <= 1'b0;
    end else if (latch_clear) begin
      lsc_cnt     <= 16'h0000;
      short_latch <= 1'b0;
    end else if (!active) begin
      lsc_cnt <= 16'h0000;
    end else if (short_eval) begin
      if (!s[`LFS_IX_SHORT])
        lsc_cnt <= 16'h0000;
      else if (lsc_cnt >= `LFS_LSC_TERMINAL)
        short_latch <= 1'b1;
      else if (sw_tick)
        lsc_cnt <= lsc_cnt + 16'h0001;
    end
  end

  // oscillator source: sync edges win, idle low hands back after delay
  always @(posedge core_clk) begin
    if (!rstn) begin
      sync_q   <= 1'b0;
      ext_mode <= 1'b0;
      idle_cnt <= {`LFS_IDLE_WIDTH{1'b0}};
    end else begin
      sync_q <= s[`LFS_IX_SYNC];
      if (sync_rise) begin
        ext_mode <= 1'b1;
        idle_cnt <= {`LFS_IDLE_WIDTH{1'b0}};
      end else if (!ext_mode || s[`LFS_IX_SYNC]) begin
        idle_cnt <= {`LFS_IDLE_WIDTH{1'b0}};
      end else if (idle_cnt >= SYNC_WAIT_LAST) begin
        ext_mode <= 1'b0;
        idle_cnt <= {`LFS_IDLE_WIDTH{1'b0}};
      end else begin
        idle_cnt <= idle_cnt + {{(`LFS_IDLE_WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  // internal oscillator divider; parked while sync drives the converter
  always @(posedge core_clk) begin
    if (!rstn) begin
      div_cnt  <= 16'h0000;
      int_tick <= 1'b0;
    end else if (ext_mode || !en) begin
      div_cnt  <= 16'h0000;
      int_tick <= 1'b0;
    end else if (osc_last) begin
      div_cnt  <= 16'h0000;
      int_tick <= 1'b1;
    end else begin
      div_cnt  <= div_cnt + 16'h0001;
      int_tick <= 1'b0;
    end
  end

  // converter sequencing
  always @* begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (run_ok)
          next_state = stop_sw ? ST_HOLD : ST_RUN;
      end
      ST_RUN: begin
        if (!run_ok)
          next_state = any_latch ? ST_LATCH : ST_OFF;
        else if (stop_sw)
          next_state = ST_HOLD;
      end
      ST_HOLD: begin
        if (!run_ok)
          next_state = any_latch ? ST_LATCH : ST_OFF;
        else if (!stop_sw)
          next_state = ST_RUN;
      end
      ST_LATCH: begin
        if (latch_clear)
          next_state = ST_OFF;
      end
      default: next_state = ST_OFF;
    endcase
  end

  always @(posedge core_clk) begin
    if (!rstn)
      state <= ST_OFF;
    else
      state <= next_state;
  end

  // registered outputs; discharge whenever not switching so the ramp
  // always restarts from zero
  always @(posedge core_clk) begin
    if (!rstn) begin
      switching_on         <= 1'b0;
      soft_start_discharge <= 1'b1;
      switch_tick          <= 1'b0;
      ext_sync_active      <= 1'b0;
      general_fault_out    <= 1'b0;
      general_fault_oe_n   <= 1'b1;
      led_fault_out        <= 1'b0;
      led_fault_oe_n       <= 1'b1;
    end else begin
      switching_on         <= (next_state == ST_RUN);
      soft_start_discharge <= (next_state != ST_RUN);
      // a source handover must not give two ticks in a row
      switch_tick          <= sw_tick & ~switch_tick &
                              (next_state == ST_RUN);
      ext_sync_active      <= ext_mode;
      general_fault_out    <= 1'b0;
      general_fault_oe_n   <= ~(undervoltage_lockout | thermal_shutdown | overvoltage_protect | scp_latch);
      led_fault_out        <= 1'b0;
      led_fault_oe_n       <= ~(open_latch | short_latch);
    end
  end

  // register writes; tiny divider values would stall the oscillator
  always @(posedge core_clk) begin
    if (!rstn) begin
      ctrl    <= `LFS_CTRL_RESET;
      osc_div <= `LFS_OSC_DIV_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        `LFS_ADDR_CTRL: begin
          ctrl <= reg_wdata & `LFS_CTRL_RESET;
        end
        `LFS_ADDR_OSC_DIV: begin
          if (reg_wdata < `LFS_OSC_DIV_MIN)
            osc_div <= `LFS_OSC_DIV_MIN;
          else
            osc_div <= reg_wdata;
        end
        default: begin
          ctrl <= ctrl;
        end
      endcase
    end
  end

  // read data stand only in the cycle after the strobe
  always @(posedge core_clk) begin
    if (!rstn) begin
      reg_rdata <= {`LFS_DATA_W{1'b0}};
    end else if (reg_rd) begin
      case (reg_addr)
        `LFS_ADDR_CTRL:      reg_rdata <= ctrl;
        `LFS_ADDR_OSC_DIV:   reg_rdata <= osc_div;
        `LFS_ADDR_STATUS: begin
          reg_rdata                 <= {`LFS_DATA_W{1'b0}};
          reg_rdata[`LFS_ST_UNDERVOLTAGE_LOCKOUT]   <= undervoltage_lockout;
          reg_rdata[`LFS_ST_TSD]    <= thermal_shutdown;
          reg_rdata[`LFS_ST_OVP]    <= overvoltage_protect;
          reg_rdata[`LFS_ST_OCP]    <= overcurrent_protect;
          reg_rdata[`LFS_ST_SCP]    <= scp_latch;
          reg_rdata[`LFS_ST_OPEN]   <= open_latch;
          reg_rdata[`LFS_ST_SHORT]  <= short_latch;
          reg_rdata[`LFS_ST_EXT]    <= ext_mode;
          reg_rdata[`LFS_ST_SWITCH] <= (state == ST_RUN);
        end
        `LFS_ADDR_LSC_COUNT: reg_rdata <= lsc_cnt;
        default:             reg_rdata <= {`LFS_DATA_W{1'b0}};
      endcase
    end else begin
      reg_rdata <= {`LFS_DATA_W{1'b0}};
    end
  end

endmodule // lfs_fault_supervisor
`default_nettype wire

// ==== testbench/lfs_ctrl_model.sv ====
// controller model driving enable, sync and dimming pins
`timescale 1ns/100ps
`default_nettype none
module lfs_ctrl_model (
  // clock and bench commands
  input  wire logic       core_clk,
  input  wire logic       supply_ok,
  input  wire logic       en_cmd,
  input  wire logic       sync_cmd,
  input  wire logic [1:0] dim_cmd,
  // pins toward the device
  output logic            enable_in,
  output logic            sync_in,
  output logic            dim_active_in,
  output logic            dimming_switch_out
);
  logic [4:0] ph;
  initial begin
    ph = 5'h00;
    enable_in = 1'b0;
    sync_in = 1'b0;
    dim_active_in = 1'b0;
    dimming_switch_out = 1'b0;
  end
  always @(posedge core_clk) begin
    // latched once up, so a later supply dip is the device's business
    enable_in <= en_cmd & (enable_in | supply_ok);
    ph <= (sync_cmd && ph != 5'h13) ? ph + 5'h01 : 5'h00;
    // stopped sync rests low, never parked high
    sync_in <= sync_cmd & (ph < 5'h0a);
    dim_active_in <= dim_cmd[0];
    dimming_switch_out <= dim_cmd[1];
  end
endmodule // lfs_ctrl_model
`default_nettype wire

// ==== testbench/lfs_sup_assertions.sv ====
// assertion checker bound to the fault supervisor
`timescale 1ns/100ps
`default_nettype none
module lfs_sup_assertions #(
  parameter SCP_TIMEOUT_CYCLES = 40
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // watched inputs
  input wire logic enable_in,
  input wire logic sync_in,
  input wire logic supply_below_lo,
  input wire logic temp_above_hi,
  input wire logic ovp_above_hi,
  input wire logic ovp_above_pre,
  input wire logic cs_below_limit,
  input wire logic feedback_low,
  // watched outputs
  input wire logic general_fault_oe_n,
  input wire logic led_fault_oe_n,
  input wire logic switching_on,
  input wire logic soft_start_discharge,
  input wire logic switch_tick,
  input wire logic ext_sync_active
);
  logic [9:0]  low_cnt;
  logic [23:0] fb_cnt;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // saturating, so a long quiet spell never wraps round
  always @(posedge core_clk) begin
    if (!rstn || sync_in)
      low_cnt <= 10'h000;
    else if (low_cnt != 10'h3ff)
      low_cnt <= low_cnt + 10'h001;
    if (!rstn || !feedback_low || !enable_in || ovp_above_pre)
      fb_cnt <= 24'h000000;
    else if (fb_cnt != 24'hffffff)
      fb_cnt <= fb_cnt + 24'h000001;
  end
  AST_HOT_STOP: assert property (
    temp_above_hi [*6] |-> !general_fault_oe_n && !switching_on)
    else $error("thermal fault not acted on");
  AST_OVP_STOP: assert property (
    ovp_above_hi [*6] |-> soft_start_discharge && !general_fault_oe_n)
    else $error("overvoltage not acted on");
  AST_OCP_STOP: assert property (
    cs_below_limit [*6] |-> soft_start_discharge && !switching_on)
    else $error("overcurrent not acted on");
  AST_UNDERVOLTAGE_LOCKOUT_STOP: assert property (
    supply_below_lo [*6] |-> !switching_on && !general_fault_oe_n)
    else $error("lockout not acted on");
  AST_RESUME_RAMP: assert property (
    $rose(switching_on) |-> !soft_start_discharge && $past(soft_start_discharge))
    else $error("restart without ramp release");
  AST_TICK_RUN: assert property (
    switch_tick |-> switching_on ##1 !switch_tick)
    else $error("tick outside run or too long");
  AST_OPEN_LATCH: assert property (
    (enable_in && feedback_low && ovp_above_pre && switching_on) ##1
    (enable_in && feedback_low && ovp_above_pre) [*7] |-> !led_fault_oe_n)
    else $error("led open not flagged");
  AST_SYNC_WAIT: assert property (
    $fell(ext_sync_active) && enable_in |-> low_cnt > 10'h2e4)
    else $error("internal clock back too early");
  AST_SCP_TIMEOUT: assert property (
    fb_cnt == SCP_TIMEOUT_CYCLES + 12 |-> !general_fault_oe_n)
    else $error("short timeout not latched");
endmodule // lfs_sup_assertions
bind lfs_fault_supervisor lfs_sup_assertions #(
  .SCP_TIMEOUT_CYCLES(SCP_TIMEOUT_CYCLES)
) i_chk (.core_clk, .rstn, .enable_in, .sync_in, .supply_below_lo,
  .temp_above_hi, .ovp_above_hi, .ovp_above_pre, .cs_below_limit,
  .feedback_low, .general_fault_oe_n, .led_fault_oe_n, .switching_on,
  .soft_start_discharge, .switch_tick, .ext_sync_active);
`default_nettype wire

// ==== testbench/testbench.sv ====
// self-checking bench for the fault supervisor
`timescale 1ns/100ps
`default_nettype none
`include "lfs_fault_map.vh"
module testbench;
  localparam int         OUTPUT_SHORT_PROTECT  = 40;
  localparam logic [3:0] HYST = 4'b1011;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [3:0]  set_v = 4'h0;
  logic [3:0]  clr_v = 4'h0;
  logic        ovp_above_pre = 1'b0;
  logic        feedback_low = 1'b0;
  logic        short_sense_diff = 1'b0;
  logic        supply_ok = 1'b0;
  logic        en_cmd = 1'b0;
  logic        sync_cmd = 1'b0;
  logic [1:0]  dim_cmd = 2'h0;
  logic [15:0] rv;
  int          ticks = 0;
  int          cycles = 0;
  int          fail_count = 0;
  int          comparisons = 0;
  integer      seed = 73;
  wire  [15:0] reg_rdata;
  wire         enable_in, sync_in, dim_active_in, dimming_switch_out;
  wire         gf_o, gf_oe_n, lf_o, lf_oe_n, switching_on, ssd, tick_p, ext;
  // open-drain pins with pull-ups
  wire         gen_pin = gf_oe_n ? 1'b1 : gf_o;
  wire         led_pin = lf_oe_n ? 1'b1 : lf_o;
  always #20 core_clk = ~core_clk;
  lfs_ctrl_model i_ctrl (.core_clk, .supply_ok, .en_cmd, .sync_cmd,
    .dim_cmd, .enable_in, .sync_in, .dim_active_in, .dimming_switch_out);
  lfs_fault_supervisor #(.SCP_TIMEOUT_CYCLES(OUTPUT_SHORT_PROTECT)) i_dut (.core_clk, .rstn,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .enable_in,
    .sync_in, .dim_active_in, .dimming_switch_out,
    .supply_below_lo(set_v[3]), .supply_above_hi(clr_v[3]),
    .temp_above_hi(set_v[0]), .temp_below_lo(clr_v[0]),
    .ovp_above_hi(set_v[1]), .ovp_below_lo(clr_v[1]), .ovp_above_pre,
    .cs_below_limit(set_v[2]), .feedback_low, .short_sense_diff,
    .general_fault_out(gf_o), .general_fault_oe_n(gf_oe_n),
    .led_fault_out(lf_o), .led_fault_oe_n(lf_oe_n), .switching_on,
    .soft_start_discharge(ssd), .switch_tick(tick_p), .ext_sync_active(ext));
  function automatic logic [15:0] per(input int c, input int p);
    return 16'(c / p);
  endfunction
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (tick_p === 1'b1)
      ticks <= ticks + 1;
    // the long short-count run sets this ceiling
    if (cycles == 90000) begin
      $display("BAD timeout exp %0d got %0d", 90000, cycles);
      fail_count++;
      tally_and_finish;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic check(input string s, input logic [15:0] e, g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e,
                        input string s);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    check(s, e, reg_rdata);
  endtask
  task automatic count_ticks(input int c, input logic [15:0] e);
    int n0;
    n0 = ticks;
    tick(c);
    check("ticks", e, 16'(ticks - n0));
  endtask
  // two cycles so the synchroniser cannot miss it
  task automatic pulse_clr(input int i);
    clr_v[i] <= 1'b1;
    tick(2);
    clr_v[i] <= 1'b0;
    tick(8);
  endtask
  initial begin
    tick(5);
    rstn <= 1'b1;
    tick(6);
    check("gen", 16'h0000, gen_pin);
    rd_chk(`LFS_ADDR_STATUS, 16'h0001, "status");
    rd_chk(`LFS_ADDR_CTRL, `LFS_CTRL_RESET, "ctrl");
    rd_chk(`LFS_ADDR_OSC_DIV, `LFS_OSC_DIV_RESET, "div");
    rd_chk(4'hf, 16'h0000, "unmapped");
    rv = 16'($random(seed));
    reg_write(`LFS_ADDR_CTRL, rv);
    rd_chk(`LFS_ADDR_CTRL, {15'h0000, rv[0]}, "ctrl");
    reg_write(`LFS_ADDR_CTRL, `LFS_CTRL_RESET);
    reg_write(`LFS_ADDR_OSC_DIV, 16'h0001);
    rd_chk(`LFS_ADDR_OSC_DIV, `LFS_OSC_DIV_MIN, "div");
    reg_write(`LFS_ADDR_OSC_DIV, 16'h000a);
    pulse_clr(3);
    check("gen", 16'h0001, gen_pin);
    supply_ok <= 1'b1;
    en_cmd <= 1'b1;
    tick(8);
    check("run", 16'h0002, {switching_on, ssd});
    count_ticks(100, per(100, 10));
    reg_write(`LFS_ADDR_STATUS, 16'hffff);
    rd_chk(`LFS_ADDR_STATUS, 16'h0100, "status");
    sync_cmd <= 1'b1;
    tick(60);
    check("ext", 16'h0001, ext);
    count_ticks(200, per(200, 20));
    sync_cmd <= 1'b0;
    tick(700);
    check("ext", 16'h0001, ext);
    tick(100);
    check("ext", 16'h0000, ext);
    count_ticks(100, per(100, 10));
    reg_write(`LFS_ADDR_CTRL, 16'h0000);
    sync_cmd <= 1'b1;
    tick(60);
    check("ext", 16'h0000, ext);
    sync_cmd <= 1'b0;
    tick(8);
    reg_write(`LFS_ADDR_CTRL, `LFS_CTRL_RESET);
    for (int i = 0; i < 4; i++) begin
      set_v[i] <= 1'b1;
      tick(8);
      check("stop", 16'h0001, {switching_on, ssd});
      check("gen", 16'(!HYST[i]), gen_pin);
      set_v[i] <= 1'b0;
      tick(8);
      check("hyst", 16'(!HYST[i]), switching_on);
      pulse_clr(i);
      check("resume", 16'h0002, {switching_on, ssd});
    end
    repeat (3) begin
      feedback_low <= 1'b1;
      tick(20 + ($random(seed) & 15));
      feedback_low <= 1'b0;
      tick(8);
      check("gen", 16'h0003, {gen_pin, switching_on});
    end
    feedback_low <= 1'b1;
    tick(OUTPUT_SHORT_PROTECT + 20);
    check("gen", 16'h0000, gen_pin);
    rd_chk(`LFS_ADDR_STATUS, 16'h0010, "status");
    feedback_low <= 1'b0;
    tick(8);
    check("latched", 16'h0000, switching_on);
    en_cmd <= 1'b0;
    tick(4);
    en_cmd <= 1'b1;
    tick(8);
    check("gen", 16'h0003, {gen_pin, switching_on});
    feedback_low <= 1'b1;
    ovp_above_pre <= 1'b1;
    tick(10);
    feedback_low <= 1'b0;
    ovp_above_pre <= 1'b0;
    tick(8);
    check("led", 16'h0000, led_pin);
    set_v[3] <= 1'b1;
    tick(8);
    set_v[3] <= 1'b0;
    pulse_clr(3);
    check("led", 16'h0003, {led_pin, switching_on});
    reg_write(`LFS_ADDR_OSC_DIV, `LFS_OSC_DIV_MIN);
    dim_cmd <= 2'h1;
    tick(4);
    short_sense_diff <= 1'b1;
    tick(100);
    rd_chk(`LFS_ADDR_LSC_COUNT, 16'h0000, "count");
    // 40 cycles of dimming switch high at a 2-cycle period give 20 steps
    dim_cmd <= 2'h3;
    tick(40);
    dim_cmd <= 2'h1;
    tick(8);
    rd_chk(`LFS_ADDR_LSC_COUNT, 16'h0014, "count");
    dim_cmd <= 2'h0;
    repeat (3) begin
      short_sense_diff <= 1'b1;
      tick(50 + ($random(seed) & 255));
      short_sense_diff <= 1'b0;
      tick(8);
      rd_chk(`LFS_ADDR_LSC_COUNT, 16'h0000, "count");
      check("led", 16'h0001, led_pin);
    end
    short_sense_diff <= 1'b1;
    tick(2 * `LFS_LSC_TERMINAL - 40);
    check("led", 16'h0001, led_pin);
    tick(80);
    check("led", 16'h0000, {led_pin, switching_on});
    tally_and_finish;
  end
endmodule // testbench
`default_nettype wire
